//--- osp_map.svh
// osp_map.svh: register addresses, field positions, reset values and counts
// assumes byte addresses on the register port and 8-bit register data
`ifndef OSP_MAP_SVH
`define OSP_MAP_SVH

`define OSP_ADDR_SETTLE       32'hFFFFF6C0
`define OSP_ADDR_RING         32'hFFFFF80C
`define OSP_ADDR_SERCLK       32'hFFFFF868

`define OSP_RST_SETTLE        3'h3
`define OSP_RST_RING          1'h0
`define OSP_RST_SER_EN        1'h0
`define OSP_RST_SER_THRU      1'h0
`define OSP_RST_SER_DIV       2'h0

`define OSP_BIT_RING_HALT     0
`define OSP_BIT_SER_EN        4
`define OSP_BIT_SER_THRU      3
`define OSP_BIT_SER_DIV_HI    1
`define OSP_BIT_SER_DIV_LO    0
`define OSP_BIT_SETTLE_HI     2
`define OSP_BIT_SETTLE_LO     0

`define OSP_SETTLE_BASE_EXP   5'h0A
`define OSP_SETTLE_MAX_CODE   3'h6
`define OSP_SETTLE_CNT_W      17

`define OSP_SER_DIV_BASE      3'h2
`define OSP_PLL_X12_MULT      4'hC
`define OSP_PLL_X10_MULT      4'hA
`define OSP_PRE_THRU_VAL      3'h1
`define OSP_PRE_DIV_BASE      3'h2
`define OSP_SYSDIV_CODE_1     2'h3
`define OSP_SYSDIV_CODE_2     2'h2
`define OSP_SYSDIV_VAL_1      3'h1
`define OSP_SYSDIV_VAL_2      3'h2
`define OSP_SYSDIV_VAL_4      3'h4

`endif

//--- osp_pkg.sv
// osp_pkg.sv: state types of the settle and clock select block
// assumes osp_map.svh for all numeric constants
`default_nettype none
package osp_pkg;

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       s3;
        logic       level;
        logic       rise;
    } osp_sync_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [2:0]  code;
        logic [16:0] cnt;
    } osp_timer_t;

    typedef struct packed {
        logic       ring_halt;
        logic [2:0] settle_code;
        logic       ser_en;
        logic       ser_thru;
        logic [1:0] ser_div;
        logic [7:0] rdata;
        logic [2:0] ser_cnt;
        logic       ser_clk;
        logic [3:0] a_mult;
        logic [4:0] a_div;
        logic [3:0] b_mult;
        logic [4:0] b_div;
    } osp_top_t;

endpackage : osp_pkg
`default_nettype wire

//--- osp_settle_if.sv
// osp_settle_if.sv: link between the register side and the settle timer
// assumes one clock shared by both ends
`default_nettype none
interface osp_settle_if;
    logic       start;
    logic [2:0] code;
    logic       osc_tick;
    logic       busy;
    logic       done;

    modport ctrl  (output start, output code, output osc_tick, input busy, input done);
    modport timer (input start, input code, input osc_tick, output busy, output done);
endinterface : osp_settle_if
`default_nettype wire

//--- osp_pin_sync.sv
// osp_pin_sync.sv: three-stage synchroniser with agreement filter
// assumes the pin is asynchronous to clk
`include "osp_map.svh"
`default_nettype none
module osp_pin_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    import osp_pkg::*;

    osp_sync_t st;
    osp_sync_t next_st;

    always_comb begin
        next_st       = st;
        next_st.s1    = pin;
        next_st.s2    = st.s1;
        next_st.s3    = st.s2;
        next_st.rise  = 1'b0;
        // only a level seen on two stages counts
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
            next_st.rise  = st.s3 & ~st.level;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
    assign rise  = st.rise;
endmodule // osp_pin_sync
`default_nettype wire

//--- osp_settle_timer.sv
// osp_settle_timer.sv: power-of-two settle counter on main oscillator ticks
// assumes osc_tick is one cycle per main oscillator rising edge
`include "osp_map.svh"
`default_nettype none
module osp_settle_timer #(
    parameter int CNT_W = `OSP_SETTLE_CNT_W
) (
    input  wire logic clk,
    input  wire logic rst,
    osp_settle_if.timer sif
);
    import osp_pkg::*;

    if (CNT_W != `OSP_SETTLE_CNT_W) begin : g_bad_width
        $error("osp_settle_timer: counter width must hold the longest wait");
    end

    osp_timer_t st;
    osp_timer_t next_st;
    logic [2:0]  eff_code;
    logic [4:0]  exp_val;
    logic [16:0] last_val;

    always_comb begin
        // prohibited code falls back to the longest wait, never a short one
        eff_code = (st.code > `OSP_SETTLE_MAX_CODE) ? `OSP_SETTLE_MAX_CODE : st.code;
        exp_val  = `OSP_SETTLE_BASE_EXP + {2'h0, eff_code};
        // last count is 2^n - 1, so the wait is exactly 2^n ticks
        last_val = (17'h1 << exp_val) - 17'h1;
        next_st      = st;
        next_st.done = 1'b0;
        if (sif.start) begin
            next_st.busy = 1'b1;
            next_st.code = sif.code;
            next_st.cnt  = '0;
        end else if (st.busy && sif.osc_tick) begin
            // counts main oscillator periods, releases at 2^n
            if (st.cnt == last_val) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.cnt  = '0;
            end else begin
                next_st.cnt = st.cnt + 17'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // the wait after reset uses the reset code
            st.busy <= 1'b1;
            st.done <= 1'b0;
            st.code <= `OSP_RST_SETTLE;
            st.cnt  <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sif.busy = st.busy;
    assign sif.done = st.done;
endmodule // osp_settle_timer
`default_nettype wire

//--- osp_clock_ctrl.sv
// osp_clock_ctrl.sv: ring oscillator stop, settle wait select, serial extended
// clock prescaler and the two PLL ratio paths of the clock generator
// assumes software writes whole bytes and one clock MCLK; oscillator and PLL
// clocks arrive as pins and are sampled
//
// Functional notes
// - ring osc register: bit 0 stops oscillator, reset zero, upper bits read zero
// - settle select register resets to three, three writable bits, rest read zero
// - settle codes 0..6 give 2^10..2^16 oscillator periods; code 7 prohibited
// - selected interval applies on STOP release and on idle release
// - serial prescaler bit 4 enables extended clock; register resets to zero
// - serial prescaler bit 3 passes the PLL peripheral clock undivided
// - serial prescaler bits 1:0 divide by 2, 3, 4 or 5
// - first PLL multiplies by 12, second by 10
// - clock-through mode passes input clock without multiplication
// - PLL output is osc times multiplier over prescaler and system divider
// - normal operation resumes only after the settle wait elapses
`include "osp_map.svh"
`default_nettype none
module osp_clock_ctrl #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 8
) (
    input  wire logic              MCLK,
    input  wire logic              RESET,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic      [DATA_W-1:0] REG_RDATA,
    input  wire logic              MAIN_OSC_CLOCK,
    input  wire logic              PLL_PERIPHERAL_CLOCK,
    input  wire logic              STOP_RELEASE,
    input  wire logic              IDLE_RELEASE,
    input  wire logic              CLOCK_THROUGH,
    input  wire logic [1:0]        PLL_A_PRE_CODE,
    input  wire logic              PLL_A_PRE_THRU,
    input  wire logic [1:0]        PLL_B_PRE_CODE,
    input  wire logic              PLL_B_PRE_THRU,
    input  wire logic [1:0]        SYS_DIV_CODE,
    output logic                   RING_OSC_HALT,
    output logic                   CLOCKS_RELEASED,
    output logic                   SETTLE_DONE,
    output logic                   SERIAL_EXT_CLK,
    output logic [3:0]             PLL_X12_MULT,
    output logic [4:0]             PLL_X12_DIV,
    output logic [3:0]             PLL_X10_MULT,
    output logic [4:0]             PLL_X10_DIV
);
    import osp_pkg::*;

    if (ADDR_W != 32 || DATA_W != 8) begin : g_bad_bus
        $error("osp_clock_ctrl: register port must be 32-bit address, 8-bit data");
    end

    osp_top_t st;
    osp_top_t next_st;

    osp_settle_if sif ();

    logic       osc_rise;
    logic       pclk_level;
    logic       pclk_rise;
    logic       hit_settle;
    logic       hit_ring;
    logic       hit_serclk;
    logic [2:0] ser_n;
    logic [2:0] ser_half;
    logic [2:0] ser_cnt_next;
    logic [2:0] sys_div;
    logic [2:0] pre_a;
    logic [2:0] pre_b;

    osp_pin_sync u_osc_sync (
        .clk   (MCLK),
        .rst   (RESET),
        .pin   (MAIN_OSC_CLOCK),
        .level (),
        .rise  (osc_rise)
    );

    osp_pin_sync u_pclk_sync (
        .clk   (MCLK),
        .rst   (RESET),
        .pin   (PLL_PERIPHERAL_CLOCK),
        .level (pclk_level),
        .rise  (pclk_rise)
    );

    osp_settle_timer #(
        .CNT_W (`OSP_SETTLE_CNT_W)
    ) u_timer (
        .clk (MCLK),
        .rst (RESET),
        .sif (sif.timer)
    );

    // stop release waits for stabilization, idle release for setup
    assign sif.start    = STOP_RELEASE | IDLE_RELEASE;
    assign sif.code     = st.settle_code;
    assign sif.osc_tick = osc_rise;

    assign hit_settle = (REG_ADDR == `OSP_ADDR_SETTLE);
    assign hit_ring   = (REG_ADDR == `OSP_ADDR_RING);
    assign hit_serclk = (REG_ADDR == `OSP_ADDR_SERCLK);

    // serial divider: code 0..3 divides by 2..5
    assign ser_n    = `OSP_SER_DIV_BASE + {1'b0, st.ser_div};
    assign ser_half = ser_n >> 1;

    always_comb begin
        if (st.ser_cnt >= ser_n - 3'h1) begin
            ser_cnt_next = 3'h0;
        end else begin
            ser_cnt_next = st.ser_cnt + 3'h1;
        end
    end

    // input prescaler: through gives 1, else code 0..3 gives 2..5
    assign pre_a = PLL_A_PRE_THRU ? `OSP_PRE_THRU_VAL
                                  : `OSP_PRE_DIV_BASE + {1'b0, PLL_A_PRE_CODE};
    assign pre_b = PLL_B_PRE_THRU ? `OSP_PRE_THRU_VAL
                                  : `OSP_PRE_DIV_BASE + {1'b0, PLL_B_PRE_CODE};

    // system divider; the prohibited code is treated as the slowest
    always_comb begin
        unique case (SYS_DIV_CODE)
            `OSP_SYSDIV_CODE_1: begin
                sys_div = `OSP_SYSDIV_VAL_1;
            end
            `OSP_SYSDIV_CODE_2: begin
                sys_div = `OSP_SYSDIV_VAL_2;
            end
            default: begin
                sys_div = `OSP_SYSDIV_VAL_4;
            end
        endcase
    end

    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;

        // register writes; every write carries the whole byte
        if (REG_WR) begin
            if (hit_ring) begin
                next_st.ring_halt = REG_WDATA[`OSP_BIT_RING_HALT];
            end
            if (hit_settle) begin
                next_st.settle_code = REG_WDATA[`OSP_BIT_SETTLE_HI:`OSP_BIT_SETTLE_LO];
            end
            // no lock against PLL mode here: software keeps it stable
            if (hit_serclk) begin
                next_st.ser_en   = REG_WDATA[`OSP_BIT_SER_EN];
                next_st.ser_thru = REG_WDATA[`OSP_BIT_SER_THRU];
                next_st.ser_div  = REG_WDATA[`OSP_BIT_SER_DIV_HI:`OSP_BIT_SER_DIV_LO];
            end
        end

        // reads answer one cycle later; unmapped and reserved bits read zero
        if (REG_RD) begin
            if (hit_ring) begin
                next_st.rdata[`OSP_BIT_RING_HALT] = st.ring_halt;
            end
            if (hit_settle) begin
                next_st.rdata[`OSP_BIT_SETTLE_HI:`OSP_BIT_SETTLE_LO] = st.settle_code;
            end
            if (hit_serclk) begin
                next_st.rdata[`OSP_BIT_SER_EN]   = st.ser_en;
                next_st.rdata[`OSP_BIT_SER_THRU] = st.ser_thru;
                next_st.rdata[`OSP_BIT_SER_DIV_HI:`OSP_BIT_SER_DIV_LO] = st.ser_div;
            end
        end

        // extended clock; held low while disabled
        if (!st.ser_en) begin
            next_st.ser_cnt = 3'h0;
            next_st.ser_clk = 1'b0;
        end else if (st.ser_thru) begin
            next_st.ser_cnt = 3'h0;
            next_st.ser_clk = pclk_level;
        end else if (pclk_rise) begin
            // odd ratios give an uneven duty cycle, period is exact
            next_st.ser_cnt = ser_cnt_next;
            next_st.ser_clk = (ser_cnt_next < ser_half);
        end

        // PLL ratios; clock-through bypasses multiplication
        if (CLOCK_THROUGH) begin
            next_st.a_mult = 4'h1;
            next_st.a_div  = 5'h01;
            next_st.b_mult = 4'h1;
            next_st.b_div  = 5'h01;
        end else begin
            next_st.a_mult = `OSP_PLL_X12_MULT;
            next_st.b_mult = `OSP_PLL_X10_MULT;
            next_st.a_div  = 5'(pre_a) * 5'(sys_div);
            next_st.b_div  = 5'(pre_b) * 5'(sys_div);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st.ring_halt   <= `OSP_RST_RING;
            st.settle_code <= `OSP_RST_SETTLE;
            st.ser_en      <= `OSP_RST_SER_EN;
            st.ser_thru    <= `OSP_RST_SER_THRU;
            st.ser_div     <= `OSP_RST_SER_DIV;
            st.rdata       <= 8'h00;
            st.ser_cnt     <= 3'h0;
            st.ser_clk     <= 1'b0;
            st.a_mult      <= 4'h1;
            st.a_div       <= 5'h01;
            st.b_mult      <= 4'h1;
            st.b_div       <= 5'h01;
        end else begin
            st <= next_st;
        end
    end

    assign REG_RDATA       = st.rdata;
    assign RING_OSC_HALT   = st.ring_halt;
    // internal clocks held until the settle counter lets go
    assign CLOCKS_RELEASED = ~sif.busy;
    assign SETTLE_DONE     = sif.done;
    assign SERIAL_EXT_CLK  = st.ser_clk;
    assign PLL_X12_MULT    = st.a_mult;
    assign PLL_X12_DIV     = st.a_div;
    assign PLL_X10_MULT    = st.b_mult;
    assign PLL_X10_DIV     = st.b_div;
endmodule // osp_clock_ctrl
`default_nettype wire

//--- osp_clock_ctrl_chk.sv
// osp_clock_ctrl_chk.sv: port-level assertions for the clock control block
// assumes it is bound onto osp_clock_ctrl; one clock MCLK, synchronous RESET
`include "osp_map.svh"
`default_nettype none
module osp_clock_ctrl_chk #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 8
) (
    input wire logic              MCLK,
    input wire logic              RESET,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire logic              MAIN_OSC_CLOCK,
    input wire logic              PLL_PERIPHERAL_CLOCK,
    input wire logic              STOP_RELEASE,
    input wire logic              IDLE_RELEASE,
    input wire logic              CLOCK_THROUGH,
    input wire logic [1:0]        PLL_A_PRE_CODE,
    input wire logic              PLL_A_PRE_THRU,
    input wire logic [1:0]        PLL_B_PRE_CODE,
    input wire logic              PLL_B_PRE_THRU,
    input wire logic [1:0]        SYS_DIV_CODE,
    input wire logic              RING_OSC_HALT,
    input wire logic              CLOCKS_RELEASED,
    input wire logic              SETTLE_DONE,
    input wire logic              SERIAL_EXT_CLK,
    input wire logic [3:0]        PLL_X12_MULT,
    input wire logic [4:0]        PLL_X12_DIV,
    input wire logic [3:0]        PLL_X10_MULT,
    input wire logic [4:0]        PLL_X10_DIV
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sh_en;
    logic [2:0] pa;
    logic [2:0] pb;
    logic [2:0] sy;
    logic [4:0] ea;
    logic [4:0] eb;
    // shadow of the serial enable bit, since only ports are visible here
    always_ff @(posedge MCLK) begin
        if (RESET) sh_en <= 1'b0;
        else if (REG_WR && REG_ADDR == `OSP_ADDR_SERCLK) sh_en <= REG_WDATA[4];
    end
    assign pa = PLL_A_PRE_THRU ? 3'h1 : 3'(PLL_A_PRE_CODE) + 3'h2;
    assign pb = PLL_B_PRE_THRU ? 3'h1 : 3'(PLL_B_PRE_CODE) + 3'h2;
    assign sy = (SYS_DIV_CODE == 2'h3) ? 3'h1 : (SYS_DIV_CODE == 2'h2) ? 3'h2 : 3'h4;
    assign ea = 5'(pa) * 5'(sy);
    assign eb = 5'(pb) * 5'(sy);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    sequence s_no_thru;
        !CLOCK_THROUGH [*3];
    endsequence
    sequence s_start;
        STOP_RELEASE || IDLE_RELEASE;
    endsequence
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data not zero outside read cycle");
    a_ring_rsvd: assert property (REG_RD && REG_ADDR == `OSP_ADDR_RING |=>
        REG_RDATA[7:1] == 7'h00) else $error("ring register upper bits not zero");
    a_settle_rsvd: assert property (REG_RD && REG_ADDR == `OSP_ADDR_SETTLE |=>
        REG_RDATA[7:3] == 5'h00) else $error("settle register upper bits not zero");
    a_ser_rsvd: assert property (REG_RD && REG_ADDR == `OSP_ADDR_SERCLK |=>
        {REG_RDATA[7:5], REG_RDATA[2]} == 4'h0) else $error("serial reserved bits set");
    a_ring_halt: assert property (REG_WR && REG_ADDR == `OSP_ADDR_RING |=>
        RING_OSC_HALT == $past(REG_WDATA[0])) else $error("halt output wrong");
    a_ser_off: assert property ((!sh_en) [*3] |-> !SERIAL_EXT_CLK)
        else $error("serial clock runs while disabled");
    a_start_hold: assert property (s_start |=> (!CLOCKS_RELEASED) [*8])
        else $error("clocks released too early");
    a_done_rise: assert property (SETTLE_DONE |->
        CLOCKS_RELEASED && !$past(CLOCKS_RELEASED)) else $error("done pulse misplaced");
    a_pll_mult: assert property (s_no_thru |-> PLL_X12_MULT == 4'hC &&
        PLL_X10_MULT == 4'hA) else $error("pll multiplier wrong");
    a_pll_div: assert property (s_no_thru |-> PLL_X12_DIV == $past(ea) &&
        PLL_X10_DIV == $past(eb)) else $error("pll divider wrong");
    a_thru_ratio: assert property (CLOCK_THROUGH [*3] |-> PLL_X12_MULT == 4'h1 &&
        PLL_X12_DIV == 5'h01 && PLL_X10_MULT == 4'h1 && PLL_X10_DIV == 5'h01)
        else $error("through mode ratio not one");
endmodule // osp_clock_ctrl_chk
bind osp_clock_ctrl osp_clock_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .MCLK(MCLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .MAIN_OSC_CLOCK(MAIN_OSC_CLOCK), .PLL_PERIPHERAL_CLOCK(PLL_PERIPHERAL_CLOCK),
    .STOP_RELEASE(STOP_RELEASE), .IDLE_RELEASE(IDLE_RELEASE), .CLOCK_THROUGH(CLOCK_THROUGH),
    .PLL_A_PRE_CODE(PLL_A_PRE_CODE), .PLL_A_PRE_THRU(PLL_A_PRE_THRU),
    .PLL_B_PRE_CODE(PLL_B_PRE_CODE), .PLL_B_PRE_THRU(PLL_B_PRE_THRU),
    .SYS_DIV_CODE(SYS_DIV_CODE), .RING_OSC_HALT(RING_OSC_HALT),
    .CLOCKS_RELEASED(CLOCKS_RELEASED), .SETTLE_DONE(SETTLE_DONE),
    .SERIAL_EXT_CLK(SERIAL_EXT_CLK), .PLL_X12_MULT(PLL_X12_MULT), .PLL_X12_DIV(PLL_X12_DIV),
    .PLL_X10_MULT(PLL_X10_MULT), .PLL_X10_DIV(PLL_X10_DIV));
`default_nettype wire

//--- osp_clock_ctrl_tb.sv
// osp_clock_ctrl_tb.sv: self-checking bench for the clock control block
// assumes osp_clock_ctrl with its checker bound; the bench drives every pin
`include "osp_map.svh"
`default_nettype none
module osp_clock_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        osc = 1'b0;
    logic        pclk = 1'b0;
    logic        stop_rel = 1'b0;
    logic        idle_rel = 1'b0;
    logic        thru = 1'b0;
    logic [1:0]  a_code = 2'h0;
    logic        a_thru = 1'b0;
    logic [1:0]  b_code = 2'h0;
    logic        b_thru = 1'b0;
    logic [1:0]  sys_code = 2'h3;
    logic        osc_run = 1'b0;
    logic        sclk_q = 1'b0;
    logic [7:0]  reg_rdata;
    logic        halt, released, done, sclk;
    logic [3:0]  x12_mult, x10_mult;
    logic [4:0]  x12_div, x10_div;
    int          ticks = 0;
    int          sx_cnt = 0;
    int          sx_per = 0;
    int          error_cnt = 0;
    int          n_checks = 0;

    osp_clock_ctrl u_dut (.MCLK(mclk), .RESET(reset), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .MAIN_OSC_CLOCK(osc), .PLL_PERIPHERAL_CLOCK(pclk), .STOP_RELEASE(stop_rel),
        .IDLE_RELEASE(idle_rel), .CLOCK_THROUGH(thru), .PLL_A_PRE_CODE(a_code),
        .PLL_A_PRE_THRU(a_thru), .PLL_B_PRE_CODE(b_code), .PLL_B_PRE_THRU(b_thru),
        .SYS_DIV_CODE(sys_code), .RING_OSC_HALT(halt), .CLOCKS_RELEASED(released),
        .SETTLE_DONE(done), .SERIAL_EXT_CLK(sclk), .PLL_X12_MULT(x12_mult),
        .PLL_X12_DIV(x12_div), .PLL_X10_MULT(x10_mult), .PLL_X10_DIV(x10_div));

    initial forever #2 mclk = ~mclk;
    always begin
        repeat (4) @(posedge mclk);
        pclk <= ~pclk;
    end
    // oscillator stops only when low, so no half tick leaks into a count
    always begin
        repeat (4) @(posedge mclk);
        if (osc_run || osc) begin
            osc <= ~osc;
            if (!osc) ticks <= ticks + 1;
        end
    end
    always @(posedge mclk) begin
        sclk_q <= sclk;
        sx_cnt <= (sclk && !sclk_q) ? 1 : sx_cnt + 1;
        if (sclk && !sclk_q) sx_per <= sx_cnt;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(32'(reg_rdata), 32'(e));
    endtask
    task automatic ser(input logic [7:0] d, input int per);
        wr(`OSP_ADDR_SERCLK, d);
        repeat (200) @(posedge mclk);
        #1;
        if (per == 0) chk(32'(sx_cnt >= 60), 32'h1);
        else chk(32'(sx_per), 32'(per));
    endtask
    task automatic pll(input int p, input int q, input int s, input logic t);
        int ea;
        int eb;
        ea = ((p == 4) ? 1 : p + 2) * ((s == 3) ? 1 : (s == 2) ? 2 : 4);
        eb = ((q == 4) ? 1 : q + 2) * ((s == 3) ? 1 : (s == 2) ? 2 : 4);
        @(posedge mclk);
        a_code <= 2'(p);
        a_thru <= (p == 4);
        b_code <= 2'(q);
        b_thru <= (q == 4);
        sys_code <= 2'(s);
        thru <= t;
        repeat (3) @(posedge mclk);
        #1;
        chk({x12_mult, x10_mult}, t ? 32'h11 : 32'hCA);
        chk({x12_div, 3'h0, x10_div}, t ? 32'h101 : 32'({5'(ea), 3'h0, 5'(eb)}));
    endtask
    // start the wait with the oscillator parked low, then count its ticks
    task automatic settle(input logic [2:0] code, input logic idle);
        int n;
        int k;
        n = 1 << (10 + code);
        k = 0;
        wr(`OSP_ADDR_SETTLE, {5'h00, code});
        osc_run = 1'b0;
        repeat (20) @(posedge mclk);
        ticks = 0;
        stop_rel <= !idle;
        idle_rel <= idle;
        @(posedge mclk);
        stop_rel <= 1'b0;
        idle_rel <= 1'b0;
        osc_run = 1'b1;
        #1;
        chk(32'(released), 32'h0);
        while (released !== 1'b1 && k < 10 * n * 8) begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk(32'(released), 32'h1);
        chk(32'(ticks), 32'(n));
        chk(32'(done), 32'h1);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd(`OSP_ADDR_SETTLE, 8'h03);
        chk(32'(released), 32'h0);
        rd(`OSP_ADDR_RING, 8'h00);
        rd(`OSP_ADDR_SERCLK, 8'h00);
        wr(`OSP_ADDR_RING, 8'hFF);
        rd(`OSP_ADDR_RING, 8'h01);
        chk(32'(halt), 32'h1);
        wr(`OSP_ADDR_RING, 8'h00);
        rd(`OSP_ADDR_RING, 8'h00);
        chk(32'(halt), 32'h0);
        wr(`OSP_ADDR_SETTLE, 8'hFF);
        wr(32'hFFFFF6C1, 8'h00);
        rd(`OSP_ADDR_SETTLE, 8'h07);
        rd(32'hFFFFF6C1, 8'h00);
        wr(`OSP_ADDR_SERCLK, 8'hFF);
        rd(`OSP_ADDR_SERCLK, 8'h1B);
        ser(8'h0B, 0);
        for (int k = 0; k < 4; k++) ser(8'h10 | 8'(k), (k + 2) * 8);
        ser(8'h18, 8);
        for (int p = 0; p < 5; p++) begin
            for (int s = 0; s < 4; s++) pll(p, (p + 1) % 5, s, 1'b0);
        end
        pll(1, 2, 3, 1'b1);
        settle(3'h0, 1'b0);
        settle(3'h1, 1'b1);
        settle(3'h2, 1'b0);
        close_out();
    end
    // whole run is about 60k cycles; well past that means a hang
    initial begin
        repeat (90000) @(posedge mclk);
        error_cnt++;
        close_out();
    end
endmodule // osp_clock_ctrl_tb
`default_nettype wire
